/* File: rtl/ssw_params.svh */
// constants for the supply supervisor and watchdog block
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

// -----------------------------------------------------------------
// time base and timing figures
// -----------------------------------------------------------------
`define SSW_CLK_MHZ      100
`define SSW_PB_QUAL_MS   40
`define SSW_RST_HOLD_MS  140
`define SSW_WDOG_MS      1000
`define SSW_MS_TO_CYC(ms) ((ms) * 1000 * `SSW_CLK_MHZ)

// -----------------------------------------------------------------
// synchroniser bit positions and reset values
// -----------------------------------------------------------------
`define SSW_NSYNC        11
`define SSW_IN_SUP_LOW   0
`define SSW_IN_BELOW     1
`define SSW_IN_NEAR      2
`define SSW_IN_MAIN_OK   3
`define SSW_IN_FAIL      4
`define SSW_IN_BUTTON_N  5
`define SSW_IN_RETAIN    6
`define SSW_IN_KICK      7
`define SSW_IN_KICK_FLT  8
`define SSW_IN_CS_N      9
`define SSW_IN_RET_FLT   10
`define SSW_SYNC_RST     11'h661
`define SSW_RETAIN_RST   1'h1

`endif

/* File: rtl/ssw_pkg.sv */
// types for the supply supervisor and watchdog block
package ssw_pkg;

    typedef logic [27:0] ssw_cnt_t;

    typedef enum logic [1:0] {
        SSW_RS_IDLE   = 2'b00,
        SSW_RS_SUPPLY = 2'b01,
        SSW_RS_BUTTON = 2'b10,
        SSW_RS_HOLD   = 2'b11
    } ssw_rst_e;

    typedef struct packed {
        ssw_rst_e rst_state;
        ssw_cnt_t hold_cnt;
        ssw_cnt_t pb_cnt;
        ssw_cnt_t wd_cnt;
        logic     kick_prev;
        logic     sup_low_prev;
        logic     retain;
        logic     reset_n;
        logic     reset;
        logic     kick_missed_n;
        logic     supply_low_flag;
        logic     early_fail_n;
        logic     battery_active_flag;
        logic     cell_switch;
        logic     main_switch;
        logic     chip_sel_out_n;
    } ssw_top_s;

endpackage

/* File: rtl/ssw_sync.sv */
// three-stage input synchroniser with second/third stage agreement
`timescale 1ns/1ps
module ssw_sync #(
    parameter int unsigned      W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           sys_clk,
    input  wire logic           arst_n,
    input  wire logic           clk_en,
    input  wire logic [W-1:0]   d_async,
    output logic [W-1:0]        q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ssw_sync_s;

    ssw_sync_s st;
    ssw_sync_s next_st;

    // -------------------------------------------------------------
    // shift chain; a bit only moves once stages two and three agree
    // -------------------------------------------------------------
    always_comb begin
        next_st    = st;
        next_st.s1 = d_async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // per-bit filter: a one-cycle disagreement is treated as noise
        next_st.q  = (st.s2 & st.s3) | (st.q & (st.s2 ^ st.s3));
    end

    // registers; all stages start at the safe value of each input
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign q = st.q;

endmodule

/* File: rtl/ssw_top.sv */
// supply supervisor: reset generation, watchdog, backup switching, gating
`timescale 1ns/1ps
`include "ssw_params.svh"
module ssw_top #(
    parameter int unsigned PB_QUAL_CYC  = `SSW_MS_TO_CYC(`SSW_PB_QUAL_MS),
    parameter int unsigned RST_HOLD_CYC = `SSW_MS_TO_CYC(`SSW_RST_HOLD_MS),
    parameter int unsigned WDOG_CYC     = `SSW_MS_TO_CYC(`SSW_WDOG_MS)
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic supply_low_cmp,
    input  wire logic below_cell_cmp,
    input  wire logic switchover_near_cmp,
    input  wire logic main_ok_cmp,
    input  wire logic fail_sense_in,
    input  wire logic button_reset_n,
    input  wire logic retain_select,
    input  wire logic retain_float,
    input  wire logic kick_in,
    input  wire logic kick_float,
    input  wire logic chip_sel_in_n,
    output logic      reset_n,
    output logic      reset,
    output logic      kick_missed_n,
    output logic      supply_low_flag,
    output logic      early_fail_n,
    output logic      battery_active_flag,
    output logic      cell_switch,
    output logic      main_switch,
    output logic      chip_sel_out_n
);
    import ssw_pkg::*;

    // -------------------------------------------------------------
    // counter limits
    // -------------------------------------------------------------
    localparam ssw_cnt_t PB_LAST   = ssw_cnt_t'(PB_QUAL_CYC - 1);
    localparam ssw_cnt_t RST_LAST  = ssw_cnt_t'(RST_HOLD_CYC - 1);
    localparam ssw_cnt_t WDOG_LAST = ssw_cnt_t'(WDOG_CYC - 1);

    // true when a counter has reached its last count
    function automatic logic cnt_hit(input ssw_cnt_t cnt, input ssw_cnt_t last);
        cnt_hit = (cnt == last);
    endfunction

    // -------------------------------------------------------------
    // input synchronisation
    // -------------------------------------------------------------
    logic [`SSW_NSYNC-1:0] raw;
    logic [`SSW_NSYNC-1:0] sy;

    // every comparator result and pin is resynchronised first
    assign raw = {retain_float, chip_sel_in_n, kick_float, kick_in,
                  retain_select, button_reset_n, fail_sense_in, main_ok_cmp,
                  switchover_near_cmp, below_cell_cmp, supply_low_cmp};

    ssw_sync #(
        .W       (`SSW_NSYNC),
        .RST_VAL (`SSW_SYNC_RST)
    ) u_sync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .d_async (raw),
        .q       (sy)
    );

    logic sup_low;
    logic below;
    logic near;
    logic main_ok;
    logic fail_ok;
    logic button_n;
    logic retain_eff;
    logic kick;
    logic kick_off;
    logic cs_n;
    logic supply_bad;

    // named views of the synchronised inputs
    assign sup_low    = sy[`SSW_IN_SUP_LOW];
    assign below      = sy[`SSW_IN_BELOW];
    assign near       = sy[`SSW_IN_NEAR];
    assign main_ok    = sy[`SSW_IN_MAIN_OK];
    assign fail_ok    = sy[`SSW_IN_FAIL];
    assign button_n   = sy[`SSW_IN_BUTTON_N];
    assign kick       = sy[`SSW_IN_KICK];
    assign kick_off   = sy[`SSW_IN_KICK_FLT];
    assign cs_n       = sy[`SSW_IN_CS_N];
    // an undriven select reads as high, so backup is the default
    assign retain_eff = sy[`SSW_IN_RETAIN] | sy[`SSW_IN_RET_FLT];
    assign supply_bad = sup_low | below;

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    ssw_top_s st;
    ssw_top_s next_st;
    logic     pb_qual;
    logic     kick_edge;
    logic     wd_fire;

    // all next-state logic for the supervisor
    always_comb begin
        next_st   = st;
        pb_qual   = 1'b0;
        kick_edge = 1'b0;
        wd_fire   = 1'b0;

        // retention select caught on the falling crossing of the threshold
        next_st.sup_low_prev = sup_low;
        if (sup_low && !st.sup_low_prev) begin
            next_st.retain = retain_eff;
        end

        // main switch stays open on power-up until well above the cell
        if (main_ok) begin
            next_st.main_switch = 1'b1;
        end else if (near || below) begin
            next_st.main_switch = 1'b0;
        end

        // cell switch closes only for a latched backup request
        next_st.cell_switch = st.retain & (near | below);
        next_st.battery_active_flag = st.retain & below;

        // flags derived straight from the comparators
        next_st.supply_low_flag = ~supply_bad;
        next_st.early_fail_n    = ~below & fail_ok;
        // write protection: the buffered copy costs one cycle plus sync
        next_st.chip_sel_out_n  = sup_low | cs_n;

        // button qualification: must stay low for the full count
        if (!button_n) begin
            if (cnt_hit(st.pb_cnt, PB_LAST)) begin
                pb_qual = 1'b1;
            end else begin
                next_st.pb_cnt = st.pb_cnt + ssw_cnt_t'(1);
            end
        end else begin
            next_st.pb_cnt = '0;
        end

        // watchdog: floating kick parks the timer, edges restart it
        next_st.kick_prev = kick;
        kick_edge = !kick_off && (kick != st.kick_prev);
        if (kick_off || kick_edge) begin
            next_st.wd_cnt = '0;
        end else if (cnt_hit(st.wd_cnt, WDOG_LAST)) begin
            next_st.wd_cnt = '0;
            wd_fire = 1'b1;
        end else begin
            next_st.wd_cnt = st.wd_cnt + ssw_cnt_t'(1);
        end

        // missed-kick flag; a release always wins over a new fault
        if (kick_edge || (st.supply_low_flag && supply_bad)) begin
            next_st.kick_missed_n = 1'b1;
        end else if (wd_fire) begin
            next_st.kick_missed_n = 1'b0;
        end

        // reset pulse generator; supply faults take priority
        case (st.rst_state)
            SSW_RS_IDLE: begin
                if (supply_bad) begin
                    next_st.rst_state = SSW_RS_SUPPLY;
                end else if (pb_qual) begin
                    next_st.rst_state = SSW_RS_BUTTON;
                end else if (wd_fire) begin
                    next_st.rst_state = SSW_RS_HOLD;
                    next_st.hold_cnt  = '0;
                end
            end
            SSW_RS_SUPPLY: begin
                if (!supply_bad) begin
                    next_st.rst_state = SSW_RS_HOLD;
                    next_st.hold_cnt  = '0;
                end
            end
            SSW_RS_BUTTON: begin
                if (supply_bad) begin
                    next_st.rst_state = SSW_RS_SUPPLY;
                end else if (button_n) begin
                    // hold time counts from the release of the button
                    next_st.rst_state = SSW_RS_HOLD;
                    next_st.hold_cnt  = '0;
                end
            end
            SSW_RS_HOLD: begin
                if (supply_bad) begin
                    next_st.rst_state = SSW_RS_SUPPLY;
                end else if (pb_qual) begin
                    next_st.rst_state = SSW_RS_BUTTON;
                end else if (wd_fire) begin
                    next_st.hold_cnt = '0;
                end else if (cnt_hit(st.hold_cnt, RST_LAST)) begin
                    next_st.rst_state = SSW_RS_IDLE;
                end else begin
                    next_st.hold_cnt = st.hold_cnt + ssw_cnt_t'(1);
                end
            end
            default: begin
                next_st.rst_state = SSW_RS_SUPPLY;
            end
        endcase

        // both reset outputs come from the same decision
        next_st.reset_n = (next_st.rst_state == SSW_RS_IDLE);
        next_st.reset   = (next_st.rst_state != SSW_RS_IDLE);
    end

    // state register; power-on values hold everything in reset
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st                 <= '0;
            st.rst_state       <= SSW_RS_SUPPLY;
            st.reset           <= 1'b1;
            st.kick_missed_n   <= 1'b1;
            st.chip_sel_out_n  <= 1'b1;
            st.sup_low_prev    <= 1'b1;
            // content after a fresh cell is arbitrary; backup is chosen
            st.retain          <= `SSW_RETAIN_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // -------------------------------------------------------------
    // outputs, all straight from the state register
    // -------------------------------------------------------------
    assign reset_n             = st.reset_n;
    assign reset               = st.reset;
    assign kick_missed_n       = st.kick_missed_n;
    assign supply_low_flag     = st.supply_low_flag;
    assign early_fail_n        = st.early_fail_n;
    assign battery_active_flag = st.battery_active_flag;
    assign cell_switch         = st.cell_switch;
    assign main_switch         = st.main_switch;
    assign chip_sel_out_n      = st.chip_sel_out_n;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_wd_expire;
        clk_en && wd_fire && !supply_bad;
    endsequence

    sequence s_wd_effect;
        !kick_missed_n && !reset_n && reset;
    endsequence

    sequence s_thr_fall;
        clk_en && sup_low && !st.sup_low_prev;
    endsequence

    AST_RST_INV: assert property (reset == !reset_n)
        else $error("reset outputs are not inverse");

    AST_CS_GATE: assert property (clk_en && sup_low |=> chip_sel_out_n)
        else $error("chip select not forced high below threshold");

    AST_CS_PASS: assert property (clk_en && !sup_low |=> chip_sel_out_n == $past(cs_n))
        else $error("chip select not passed through");

    AST_LOW_FLAG: assert property (clk_en && supply_bad |=> !supply_low_flag)
        else $error("supply low flag not low");

    AST_RST_SUPPLY: assert property (clk_en && supply_bad |=> !reset_n)
        else $error("reset not asserted on supply fault");

    AST_EARLY_FAIL: assert property (clk_en && below |=> !early_fail_n)
        else $error("early fail not forced low below cell");

    AST_BATT_CELL: assert property (battery_active_flag |-> cell_switch)
        else $error("battery flag high without cell switch");

    AST_CELL_OFF: assert property (clk_en && !st.retain |=> !cell_switch)
        else $error("cell switch on with latched low status");

    AST_KICK_CLR: assert property (clk_en && kick_edge |=> kick_missed_n)
        else $error("kick missed not released on kick edge");

    AST_WD_FIRE: assert property (s_wd_expire |=> s_wd_effect)
        else $error("watchdog expiry without reset and flag");

    AST_HOLD_LEN: assert property ($rose(reset_n) |-> $past(st.hold_cnt) == RST_LAST)
        else $error("reset released before hold time");

    AST_PB_QUAL: assert property (
        clk_en && st.rst_state == SSW_RS_IDLE && !supply_bad && pb_qual
        |=> st.rst_state == SSW_RS_BUTTON && !reset_n)
        else $error("qualified press did not assert reset");

    AST_FLOAT_OFF: assert property (clk_en && kick_off |=> st.wd_cnt == '0)
        else $error("watchdog counting while kick floats");

    AST_RET_LATCH: assert property (s_thr_fall |=> st.retain == $past(retain_eff))
        else $error("retention status not latched on threshold crossing");

    AST_MAIN_OFF: assert property (clk_en && !main_ok && near |=> !main_switch)
        else $error("main switch closed near cell supply");

endmodule

/* File: verif/ssw_cpu_model.sv */
// processor-side model: watchdog kicks, retention choice, RAM select
`timescale 1ns/1ps
module ssw_cpu_model #(
    parameter int SLOW_GAP = 44
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic kick_run,
    input  wire logic kick_slow,
    input  wire logic ret_req,
    input  wire logic cs_req_n,
    output logic      kick_in,
    output logic      retain_select,
    output logic      chip_sel_in_n
);
    int   gap = 0;
    logic k   = 1'b0;
    logic r   = 1'b1;
    logic c   = 1'b1;
    assign kick_in       = k;
    assign retain_select = r;
    assign chip_sel_in_n = c;
    // slow mode toggles just inside the time-out, so a late restart shows
    always @(posedge sys_clk) begin
        r <= ret_req;
        c <= cs_req_n;
        if (!arst_n || !kick_run || gap >= (kick_slow ? SLOW_GAP : 9)) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
        if (arst_n && kick_run && gap >= (kick_slow ? SLOW_GAP : 9)) begin
            k <= ~k;
        end
    end
endmodule

/* File: verif/ssw_top_bench.sv */
// self-checking bench for the supply supervisor and watchdog block
`timescale 1ns/1ps
module ssw_top_bench;
    localparam int PB  = 8;
    localparam int RST = 20;
    localparam int WD  = 50;
    logic sys_clk = 1'b0, arst_n = 1'b0, supply_low_cmp = 1'b0, below_cell_cmp = 1'b0;
    logic switchover_near_cmp = 1'b0, main_ok_cmp = 1'b1, fail_sense_in = 1'b1;
    logic button_reset_n = 1'b1, retain_float = 1'b0, kick_float = 1'b0;
    logic kick_run = 1'b0, kick_slow = 1'b0, ret_req = 1'b1, cs_req_n = 1'b1;
    logic clk_en = 1'b1;
    logic kick_in, retain_select, chip_sel_in_n, reset_n, reset, kick_missed_n;
    logic supply_low_flag, early_fail_n, battery_active_flag, cell_switch;
    logic main_switch, chip_sel_out_n;
    int   error_cnt = 0;
    int   n_tests   = 0;
    int   n;

    ssw_top #(.PB_QUAL_CYC(PB), .RST_HOLD_CYC(RST), .WDOG_CYC(WD)) dut (
        .sys_clk, .arst_n, .clk_en, .supply_low_cmp, .below_cell_cmp,
        .switchover_near_cmp, .main_ok_cmp, .fail_sense_in, .button_reset_n,
        .retain_select, .retain_float, .kick_in, .kick_float, .chip_sel_in_n,
        .reset_n, .reset, .kick_missed_n, .supply_low_flag, .early_fail_n,
        .battery_active_flag, .cell_switch, .main_switch, .chip_sel_out_n);

    ssw_cpu_model cpu (
        .sys_clk, .arst_n, .kick_run, .kick_slow, .ret_req, .cs_req_n,
        .kick_in, .retain_select, .chip_sel_in_n);

    always #5 sys_clk = ~sys_clk;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic conclude;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // the #1 lets the edge's register updates land before sampling
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(input string nm, input logic seen, input logic exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", nm, exp, seen);
        end
    endtask

    // bounded wait on reset_n (sel 0) or kick_missed_n (sel 1)
    task automatic wt(input bit sel, input logic lvl, output int c);
        c = 0;
        while (((sel ? kick_missed_n : reset_n) !== lvl) && c < 400) begin
            cyc(1);
            c++;
        end
    endtask

    // both reset outputs are compared on every falling edge while arst_n is high
    always @(negedge sys_clk) if (arst_n) chk("reset_inv", reset, ~reset_n);

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        cyc(8);
        chk("reset_n", reset_n, 1'b0);
        chk("cs_out", chip_sel_out_n, 1'b1);
        chk("batt", battery_active_flag, 1'b0);
        cyc(8);
        @(posedge sys_clk);
        arst_n   <= 1'b1;
        kick_run <= 1'b1;
        wt(0, 1'b1, n);
        chk("up_hold", n >= RST && n <= RST + 8, 1'b1);
        chk("main_sw", main_switch, 1'b1);
        chk("low_flag", supply_low_flag, 1'b1);
    endtask

    task automatic t_pass(input logic v);
        @(posedge sys_clk);
        cs_req_n      <= v;
        fail_sense_in <= v;
        cyc(8);
        chk("cs_out", chip_sel_out_n, v);
        chk("early", early_fail_n, v);
        // with the enable low nothing may move, the input synchronisers included
        @(posedge sys_clk);
        clk_en        <= 1'b0;
        cs_req_n      <= ~v;
        fail_sense_in <= ~v;
        cyc(8);
        chk("cs_frozen", chip_sel_out_n, v);
        chk("early_frozen", early_fail_n, v);
        @(posedge sys_clk);
        clk_en        <= 1'b1;
        cs_req_n      <= v;
        fail_sense_in <= v;
        cyc(8);
    endtask

    task automatic t_wdog;
        @(posedge sys_clk);
        kick_slow <= 1'b1;
        cyc(3 * WD);
        chk("slow_kick", kick_missed_n, 1'b1);
        // stop right after a toggle so the time-out runs from a known kick
        @(kick_in);
        @(posedge sys_clk);
        kick_slow <= 1'b0;
        kick_run  <= 1'b0;
        cyc(WD - 12);
        chk("not_early", kick_missed_n, 1'b1);
        wt(1, 1'b0, n);
        chk("wd_fire", n >= 12 && n <= 20, 1'b1);
        chk("wd_rst", reset_n, 1'b0);
        wt(0, 1'b1, n);
        chk("wd_pulse", n >= RST - 1 && n <= RST + 4, 1'b1);
        wt(0, 1'b0, n);
        chk("wd_again", n >= WD - RST - 4 && n <= WD - RST + 4, 1'b1);
        @(posedge sys_clk);
        kick_run <= 1'b1;
        cyc(20);
        chk("kick_clr", kick_missed_n, 1'b1);
        wt(0, 1'b1, n);
        @(posedge sys_clk);
        kick_run <= 1'b0;
        wt(1, 1'b0, n);
        @(posedge sys_clk);
        supply_low_cmp <= 1'b1;
        cyc(7);
        chk("low_clr", kick_missed_n, 1'b1);
        @(posedge sys_clk);
        supply_low_cmp <= 1'b0;
        kick_run       <= 1'b1;
        wt(0, 1'b1, n);
        @(posedge sys_clk);
        kick_float <= 1'b1;
        kick_run   <= 1'b0;
        cyc(3 * WD);
        chk("float", kick_missed_n, 1'b1);
        chk("float_rst", reset_n, 1'b1);
        @(posedge sys_clk);
        kick_float <= 1'b0;
        kick_run   <= 1'b1;
        cyc(10);
    endtask

    task automatic t_button;
        @(posedge sys_clk);
        button_reset_n <= 1'b0;
        cyc(4);
        @(posedge sys_clk);
        button_reset_n <= 1'b1;
        cyc(12);
        chk("pb_short", reset_n, 1'b1);
        @(posedge sys_clk);
        button_reset_n <= 1'b0;
        wt(0, 1'b0, n);
        chk("pb_qual", n >= PB && n <= PB + 6, 1'b1);
        cyc(RST + 10);
        chk("pb_held", reset_n, 1'b0);
        @(posedge sys_clk);
        button_reset_n <= 1'b1;
        wt(0, 1'b1, n);
        chk("pb_hold", n >= RST && n <= RST + 7, 1'b1);
    endtask

    // retention request is driven opposite to the expected latch after the latch point, which must not matter
    task automatic t_fail(input logic ret, input logic flt, input logic on);
        @(posedge sys_clk);
        ret_req      <= ret;
        retain_float <= flt;
        cs_req_n     <= 1'b0;
        cyc(8);
        @(posedge sys_clk);
        supply_low_cmp <= 1'b1;
        cyc(8);
        chk("pf_rst", reset_n, 1'b0);
        chk("pf_low", supply_low_flag, 1'b0);
        chk("pf_cs", chip_sel_out_n, 1'b1);
        @(posedge sys_clk);
        ret_req             <= ~on;
        switchover_near_cmp <= 1'b1;
        main_ok_cmp         <= 1'b0;
        cyc(8);
        chk("near_cell", cell_switch, on);
        chk("near_main", main_switch, 1'b0);
        @(posedge sys_clk);
        below_cell_cmp <= 1'b1;
        cyc(8);
        chk("bel_cell", cell_switch, on);
        chk("bel_batt", battery_active_flag, on);
        chk("bel_early", early_fail_n, 1'b0);
        chk("bel_low", supply_low_flag, 1'b0);
        @(posedge sys_clk);
        below_cell_cmp      <= 1'b0;
        switchover_near_cmp <= 1'b0;
        main_ok_cmp         <= 1'b1;
        supply_low_cmp      <= 1'b0;
        retain_float        <= 1'b0;
        cs_req_n            <= 1'b1;
        cyc(8);
        chk("up_low", supply_low_flag, 1'b1);
        chk("up_batt", battery_active_flag, 1'b0);
        chk("up_main", main_switch, 1'b1);
        chk("up_early", early_fail_n, 1'b1);
        chk("up_rst", reset_n, 1'b0);
        wt(0, 1'b1, n);
        chk("up_hold", n >= RST - 6 && n <= RST + 1, 1'b1);
    endtask

    initial begin
        t_reset;
        t_pass(1'b0);
        t_pass(1'b1);
        t_wdog;
        t_button;
        t_fail(1'b1, 1'b0, 1'b1);
        t_fail(1'b0, 1'b0, 1'b0);
        t_fail(1'b0, 1'b1, 1'b1);
        conclude;
    end

    // the run needs about a thousand cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        conclude;
    end
endmodule
